// ===== rtl/flash_seq_pkg.sv
// flash_seq_pkg: register map, field positions, pin and request carriers
// assumes a 50 MHz ref_clk shared by every user of these constants
`default_nettype none

package flash_seq_pkg;

  // register byte addresses
  localparam logic [31:0] BUS_CMD_ADDR   = 32'h0c000000;
  localparam logic [31:0] MODE_CTRL_ADDR = 32'h0c000004;

  // serial_bus_command fields
  localparam int RELEASE_CMD_BIT = 4;
  localparam int ASSERT_CMD_BIT  = 3;
  localparam int FOUR_LANE_BIT   = 2;
  localparam int TWO_LANE_BIT    = 1;
  localparam int ONE_LANE_BIT    = 0;

  // serial_mode_control fields
  localparam int WIDE_ADDR_BIT   = 13;
  localparam int SPLIT_BIT       = 12;
  localparam int PIPE_DLY_HI     = 11;
  localparam int PIPE_DLY_LO     = 9;
  localparam int PIPE_EN_BIT     = 8;
  localparam int SAMPLE_EDGE_BIT = 7;
  localparam int AUTO_BIT        = 0;
  localparam logic [31:0] MODE_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] MODE_CTRL_WMASK = 32'h00003f81;

  // serial framing
  localparam logic [7:0] READ_OPCODE    = 8'h03;
  localparam logic [5:0] CMD_BITS       = 6'h08;
  localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
  localparam logic [5:0] ADDR_BITS_WIDE   = 6'h20;
  localparam int         WORD_BITS      = 32;
  localparam int         DUMMY_CLKS_DEF = 8;
  localparam int         PIPE_TAPS      = 8;

  // serial clock timing: half period as time, then in ref_clk cycles (least time, rounded up)
  localparam int REF_PERIOD_NS = 20;
  localparam int SCK_HALF_NS   = 80;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  // code equals the number of lanes in use
  typedef enum logic [2:0] {
    LANE_ONE  = 3'h1,
    LANE_TWO  = 3'h2,
    LANE_FOUR = 3'h4
  } lane_width_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  beats_m1;
  } read_req_t;

  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] dout;
    logic [3:0] oe;
  } flash_pins_t;

endpackage : flash_seq_pkg

`default_nettype wire

// ===== rtl/word_fifo.sv
// word_fifo: flip-flop FIFO with valid/ready on both sides
// assumes a single clock and synchronous active-high reset
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
    $error("word_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_nxt  = push ? wr_r + 1'b1 : wr_r;
    rd_nxt  = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

endmodule : word_fifo

`default_nettype wire

// ===== rtl/flash_seq.sv
// flash_seq: serial flash bus control, manual strobes and auto read sequencer
// assumes io_in comes straight from pads; host ports share ref_clk
//
// Function
// [RQ1] manual: release strobe drives select high
// [RQ2] manual: assert strobe drives select low
// [RQ3] manual: strobe selects four-lane width
// [RQ4] manual: strobe selects two-lane width
// [RQ5] manual: strobe selects one-lane width
// [RQ6] auto: three or four address bytes
// [RQ7] unsplit burst: one continuous serial burst
// [RQ8] split burst: fresh command every beat
// [RQ9] split access: select low only per access
// [RQ10] pipe delay field picks eight sampling delays
// [RQ11] pipe off: sample edge chooses clock
// [RQ12] pipe on: capture through delayed pipe
// [RQ13] edge bit: zero rising, one falling
// [RQ14] mode bit: zero manual, one auto
// [RQ15] zero strobes do nothing, hold nothing
// [RQ16] strobes ignored while in auto mode
`default_nettype none

module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int SCK_HALF   = SCK_HALF_CYC,
  parameter int DUMMY_CLKS = DUMMY_CLKS_DEF,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire read_req_t   req,
  output logic             data_valid,
  input  wire logic        data_ready,
  output logic      [31:0] data,
  input  wire logic [3:0]  io_in,
  output flash_pins_t      pins
);

  if (SCK_HALF < 2 || DUMMY_CLKS < 1 || DUMMY_CLKS > 32) begin : g_bad_cfg
    $error("flash_seq: half period below 2 or dummy clocks outside 1..32");
  end

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CMD   = 8'h02,
    ST_ADDR  = 8'h04,
    ST_DUMMY = 8'h08,
    ST_WAITW = 8'h10,
    ST_DATA  = 8'h20,
    ST_DRAIN = 8'h40,
    ST_GAP   = 8'h80
  } seq_state_t;

  // register state
  logic [31:0]  mode_r, mode_nxt, rdata_r, rdata_nxt;
  lane_width_t  width_r, width_nxt;
  logic         cs_man_r, cs_man_nxt, cs_n_r, cs_n_nxt;
  logic         cmd_hit;
  // sequencer state
  seq_state_t   st_r, st_nxt;
  logic [15:0]  div_r, div_nxt;
  logic         sck_r, sck_nxt;
  logic [31:0]  sh_r, sh_nxt, addr_r, addr_nxt;
  logic [5:0]   bits_r, bits_nxt;
  logic [3:0]   beats_r, beats_nxt;
  // receive state
  logic [31:0]  rx_r, rx_nxt;
  logic [5:0]   rx_cnt_r, rx_cnt_nxt, word_clks;
  logic [6:0]   dly_r, dly_nxt;
  logic [3:0]   io_meta_r, io_s_r;
  logic [PIPE_TAPS-1:0] taps;
  logic         auto_sel, wide_addr, split_en, pipe_en, edge_sel;
  logic [2:0]   pipe_dly;
  logic         run, tick, fall, rise_data, fall_data, sample, push, rx_idle;
  logic         fifo_ready;

  assign auto_sel  = mode_r[AUTO_BIT];
  assign wide_addr = mode_r[WIDE_ADDR_BIT];
  assign split_en  = mode_r[SPLIT_BIT];
  assign pipe_en   = mode_r[PIPE_EN_BIT];
  assign edge_sel  = mode_r[SAMPLE_EDGE_BIT];
  assign pipe_dly  = mode_r[PIPE_DLY_HI:PIPE_DLY_LO];

  // pad inputs come from the flash's domain
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      io_meta_r <= '0;
      io_s_r    <= '0;
    end else begin
      io_meta_r <= io_in;
      io_s_r    <= io_meta_r;
    end
  end

  // ---------------- registers ----------------
  // strobes are decoded from the write itself; nothing of them is kept
  assign cmd_hit = reg_wr && (reg_addr == BUS_CMD_ADDR) && !auto_sel; // RQ15 RQ16

  always_comb begin
    mode_nxt   = mode_r;
    width_nxt  = width_r;
    cs_man_nxt = cs_man_r;
    rdata_nxt  = rdata_r;
    if (reg_wr && reg_addr == MODE_CTRL_ADDR) begin
      mode_nxt = reg_wdata & MODE_CTRL_WMASK;
    end
    if (cmd_hit) begin
      // release outranks assert so a double strobe leaves the flash deselected
      if (reg_wdata[RELEASE_CMD_BIT]) begin
        cs_man_nxt = 1'b1; // RQ1
      end else if (reg_wdata[ASSERT_CMD_BIT]) begin
        cs_man_nxt = 1'b0; // RQ2
      end
      if (reg_wdata[ONE_LANE_BIT]) begin
        width_nxt = LANE_ONE; // RQ5
      end else if (reg_wdata[TWO_LANE_BIT]) begin
        width_nxt = LANE_TWO; // RQ4
      end else if (reg_wdata[FOUR_LANE_BIT]) begin
        width_nxt = LANE_FOUR; // RQ3
      end
    end
    if (reg_rd) begin
      rdata_nxt = (reg_addr == MODE_CTRL_ADDR) ? mode_r : '0;
    end
    // RQ14
    cs_n_nxt = auto_sel ? (st_nxt == ST_IDLE || st_nxt == ST_GAP) : cs_man_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_r   <= MODE_CTRL_RESET;
      width_r  <= LANE_ONE;
      cs_man_r <= 1'b1;
      cs_n_r   <= 1'b1;
      rdata_r  <= '0;
    end else begin
      mode_r   <= mode_nxt;
      width_r  <= width_nxt;
      cs_man_r <= cs_man_nxt;
      cs_n_r   <= cs_n_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // ---------------- sequencer ----------------
  assign run  = st_r inside {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_GAP};
  assign tick = run && (div_r == 16'(SCK_HALF - 1));
  assign fall = tick && sck_r;
  assign req_ready = auto_sel && (st_r == ST_IDLE); // RQ14

  always_comb begin
    unique case (width_r)
      LANE_FOUR: word_clks = 6'(WORD_BITS / 4);
      LANE_TWO:  word_clks = 6'(WORD_BITS / 2);
      default:   word_clks = 6'(WORD_BITS);
    endcase
  end

  always_comb begin
    st_nxt    = st_r;
    div_nxt   = run ? (tick ? '0 : div_r + 16'h0001) : '0;
    sck_nxt   = (tick && st_r != ST_GAP) ? ~sck_r : sck_r;
    sh_nxt    = sh_r;
    bits_nxt  = bits_r;
    addr_nxt  = addr_r;
    beats_nxt = beats_r;
    if (fall) begin
      sh_nxt   = {sh_r[30:0], 1'b0};
      bits_nxt = bits_r - 6'h01;
    end
    unique case (st_r)
      ST_IDLE: if (req_valid && req_ready) begin
        st_nxt    = ST_CMD;
        addr_nxt  = req.addr;
        beats_nxt = req.beats_m1;
        sh_nxt    = {READ_OPCODE, 24'h000000};
        bits_nxt  = CMD_BITS;
      end
      ST_GAP: if (tick) begin
        st_nxt   = ST_CMD; // RQ8
        sh_nxt   = {READ_OPCODE, 24'h000000};
        bits_nxt = CMD_BITS;
      end
      ST_CMD: if (fall && bits_r == 6'h01) begin
        st_nxt   = ST_ADDR;
        sh_nxt   = wide_addr ? addr_r : {addr_r[23:0], 8'h00}; // RQ6
        bits_nxt = wide_addr ? ADDR_BITS_WIDE : ADDR_BITS_NARROW; // RQ6
      end
      ST_ADDR: if (fall && bits_r == 6'h01) begin
        st_nxt   = ST_DUMMY;
        bits_nxt = 6'(DUMMY_CLKS);
      end
      ST_DUMMY: if (fall && bits_r == 6'h01) begin
        st_nxt = ST_WAITW;
      end
      // clock is parked low until the FIFO can take a whole word
      ST_WAITW: if (rx_idle && fifo_ready) begin
        st_nxt   = ST_DATA;
        bits_nxt = word_clks;
      end
      ST_DATA: if (fall && bits_r == 6'h01) begin
        st_nxt = ST_DRAIN;
      end
      // select stays low until delayed samples of the word have landed
      ST_DRAIN: if (rx_idle) begin
        if (beats_r == 4'h0) begin
          st_nxt = ST_IDLE; // RQ9
        end else begin
          beats_nxt = beats_r - 4'h1;
          addr_nxt  = addr_r + 32'h00000004;
          st_nxt    = split_en ? ST_GAP : ST_WAITW; // RQ7 RQ8 RQ9
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r    <= ST_IDLE;
      div_r   <= '0;
      sck_r   <= 1'b0;
      sh_r    <= '0;
      bits_r  <= '0;
      addr_r  <= '0;
      beats_r <= '0;
    end else begin
      st_r    <= st_nxt;
      div_r   <= div_nxt;
      sck_r   <= sck_nxt;
      sh_r    <= sh_nxt;
      bits_r  <= bits_nxt;
      addr_r  <= addr_nxt;
      beats_r <= beats_nxt;
    end
  end

  assign pins = '{cs_n: cs_n_r,
                  sck:  sck_r,
                  dout: {3'b000, sh_r[31]},
                  oe:   (st_r inside {ST_CMD, ST_ADDR}) ? 4'h1 : 4'h0};

  // ---------------- receive path ----------------
  assign rise_data = tick && !sck_r && (st_r == ST_DATA);
  assign fall_data = fall && (st_r == ST_DATA);
  assign taps      = {dly_r, fall_data};
  // pipe taps a delayed copy of the falling edge; otherwise pick an edge
  assign sample = pipe_en ? taps[pipe_dly] // RQ10 RQ12
                          : (edge_sel ? fall_data : rise_data); // RQ11 RQ13
  assign rx_idle = (rx_cnt_r == '0) && !push;

  always_comb begin
    dly_nxt    = {dly_r[5:0], fall_data};
    rx_nxt     = rx_r;
    rx_cnt_nxt = rx_cnt_r;
    push       = 1'b0;
    if (sample) begin
      unique case (width_r)
        LANE_FOUR: rx_nxt = {rx_r[27:0], io_s_r};
        LANE_TWO:  rx_nxt = {rx_r[29:0], io_s_r[1:0]};
        default:   rx_nxt = {rx_r[30:0], io_s_r[1]};
      endcase
      if (rx_cnt_r == word_clks - 6'h01) begin
        rx_cnt_nxt = '0;
        push       = 1'b1;
      end else begin
        rx_cnt_nxt = rx_cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dly_r    <= '0;
      rx_r     <= '0;
      rx_cnt_r <= '0;
    end else begin
      dly_r    <= dly_nxt;
      rx_r     <= rx_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (rx_nxt),
    .out_valid (data_valid),
    .out_ready (data_ready),
    .out_data  (data)
  );

  assign reg_rdata = rdata_r;

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_release_cs: assert property (cmd_hit && reg_wdata[RELEASE_CMD_BIT]
    |=> pins.cs_n) else $error("release strobe left select low"); // RQ1
  a_assert_cs: assert property (cmd_hit && reg_wdata[ASSERT_CMD_BIT]
    && !reg_wdata[RELEASE_CMD_BIT] |=> !pins.cs_n)
    else $error("assert strobe left select high"); // RQ2
  a_quad_width: assert property (cmd_hit && reg_wdata[2:0] == 3'h4
    |=> width_r == LANE_FOUR) else $error("four-lane strobe ignored"); // RQ3
  a_dual_width: assert property (cmd_hit && reg_wdata[1:0] == 2'h2
    |=> width_r == LANE_TWO) else $error("two-lane strobe ignored"); // RQ4
  a_single_width: assert property (cmd_hit && reg_wdata[ONE_LANE_BIT]
    |=> width_r == LANE_ONE) else $error("one-lane strobe ignored"); // RQ5
  a_addr_length: assert property ($rose(st_r == ST_ADDR)
    |-> bits_r == (wide_addr ? 6'h20 : 6'h18)) else $error("address length wrong"); // RQ6
  a_burst_joined: assert property (st_r == ST_DRAIN && rx_idle && beats_r != 4'h0
    && !split_en |=> !pins.cs_n [*8]) else $error("unsplit burst dropped select"); // RQ7
  a_split_cmd: assert property (st_r == ST_DRAIN && rx_idle && beats_r != 4'h0
    && split_en |=> ##[1:3] pins.cs_n ##1 (st_r == ST_GAP) [*1] ##[0:40] st_r == ST_CMD)
    else $error("split burst did not reissue command"); // RQ8 RQ9
  a_split_release: assert property (st_r == ST_DRAIN && rx_idle && beats_r == 4'h0
    |=> ##1 pins.cs_n) else $error("select held after access"); // RQ9
  a_pipe_delay1: assert property (pipe_en && pipe_dly == 3'h1 && sample
    |-> $fell(pins.sck)) else $error("pipe delay 1 not honoured"); // RQ10
  a_pipe_delay0: assert property (pipe_en && pipe_dly == 3'h0 && sample
    |=> $fell(pins.sck)) else $error("pipe delay 0 not honoured"); // RQ12
  a_rise_sample: assert property (!pipe_en && !edge_sel && sample
    |=> $rose(pins.sck)) else $error("rising sample wrong"); // RQ11 RQ13
  a_fall_sample: assert property (!pipe_en && edge_sel && sample
    |=> $fell(pins.sck)) else $error("falling sample wrong"); // RQ11 RQ13
  a_manual_quiet: assert property (!auto_sel && st_r == ST_IDLE
    |=> st_r == ST_IDLE) else $error("sequencer started in manual mode"); // RQ14
  a_zero_strobe: assert property (reg_wr && reg_addr == BUS_CMD_ADDR && reg_wdata == '0
    && !auto_sel |=> $stable(width_r) && $stable(cs_man_r))
    else $error("zero strobe changed state"); // RQ15
  a_auto_ignore: assert property (reg_wr && reg_addr == BUS_CMD_ADDR && auto_sel
    |=> $stable(width_r) && $stable(cs_man_r))
    else $error("strobe accepted in auto mode"); // RQ16

  c_split_burst: cover property (split_en && st_r == ST_GAP ##[1:200] st_r == ST_CMD);
  c_wide_addr:   cover property (wide_addr && $rose(st_r == ST_ADDR));
  c_pipe_word:   cover property (pipe_en && push);
  c_fifo_full:   cover property (!fifo_ready && st_r == ST_WAITW);

endmodule : flash_seq

`default_nettype wire

// ===== dv/flash_model.sv
// flash_model: behavioural serial flash answering a read on io0
// assumes the bench sets lane count and address width to match the controller
`default_nettype none

module flash_model
  import flash_seq_pkg::*;
#(
  parameter int DUMMY = 8
) (
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       io0,
  input  wire logic       wide,
  input  wire logic [2:0] lanes,
  output logic      [3:0] m_out,
  output logic      [3:0] m_oe,
  output logic      [7:0] cmd,
  output int              frames,
  output int              rises
);
  timeunit 1ns;
  timeprecision 1ns;

  int          cnt;
  int          pos;
  logic [31:0] adr;
  logic [31:0] word;

  initial begin
    {m_out, m_oe, cmd, adr} = '0;
    cnt = 0;
    frames = 0;
    rises = 0;
  end

  always @(negedge cs_n) frames++;

  // released lines fall back to the bench's toggling pattern
  // a narrow address only fills the low 24 bits, so each frame starts from zero
  always @(posedge cs_n) begin
    cnt = 0;
    m_oe = '0;
    adr = '0;
  end

  always @(posedge sck) if (!cs_n) begin
    if (cnt < 8) cmd = {cmd[6:0], io0};
    else if (cnt < (wide ? 40 : 32)) adr = {adr[30:0], io0};
    cnt++;
    rises++;
  end

  // data leaves shortly after each falling clock, as a real part would
  always @(negedge sck) if (!cs_n) begin
    pos = cnt - (wide ? 40 : 32) - DUMMY;
    if (pos >= 0) begin
      word = ~(adr + 32'(pos * lanes / 32 * 4));
      word = word << (pos * lanes % 32);
      #2;
      if (!cs_n) begin
        m_oe  = lanes == 3'h1 ? 4'h2 : (lanes == 3'h2 ? 4'h3 : 4'hf);
        m_out = lanes == 3'h1 ? {2'h0, word[31], 1'h0} :
                (lanes == 3'h2 ? {2'h0, word[31:30]} : word[31:28]);
      end
    end
  end

endmodule : flash_model

`default_nettype wire

// ===== dv/testbench.sv
// testbench: register strobes, mode settings and auto reads against a flash model
// assumes flash_seq with a 4-word FIFO so that a stalled host fills it quickly
`default_nettype none

module testbench
  import flash_seq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  logic        req_valid = 0, data_ready = 0, req_ready, data_valid, wide = 0, stall = 0;
  logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, data;
  logic [31:0] lfsr = 32'hc8df0b1d;
  logic [31:0] cfg [4] = '{32'h0, 32'h80, 32'h100, 32'h300};
  logic [3:0]  io_in, m_out, m_oe, noise = '0;
  logic [2:0]  lanes = 3'h1;
  logic [7:0]  cmd;
  read_req_t   req = '0;
  flash_pins_t pins;
  int          frames, rises, err_total = 0, checked = 0;
  logic [31:0] got [$], exp [$];

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) noise <= ~noise;
  assign io_in = (pins.oe & pins.dout) | (~pins.oe & m_oe & m_out) | (~pins.oe & ~m_oe & noise);

  flash_seq #(.FIFO_DEPTH(4)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .data_valid(data_valid),
    .data_ready(data_ready), .data(data), .io_in(io_in), .pins(pins));

  flash_model flash_u (
    .cs_n(pins.cs_n), .sck(pins.sck), .io0(io_in[0]), .wide(wide), .lanes(lanes),
    .m_out(m_out), .m_oe(m_oe), .cmd(cmd), .frames(frames), .rises(rises));

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step

  // host pulls words at random unless a scenario stalls it
  always @(negedge ref_clk) begin
    lfsr = step(lfsr);
    data_ready = !stall && lfsr[1:0] != 2'h0;
  end
  always @(posedge ref_clk) if (!reset && data_valid && data_ready) got.push_back(data);

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge ref_clk);
    reg_wr = 0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] want);
    @(negedge ref_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge ref_clk);
    reg_rd = 0;
    check(reg_rdata, want);
  endtask : rd

  task automatic strobe(input logic [31:0] a, input logic [31:0] d, input logic cs);
    wr(a, d);
    @(negedge ref_clk);
    check(32'(pins.cs_n), 32'(cs));
  endtask : strobe

  task automatic burst(input int n, input bit sp, input bit hold);
    logic [31:0] a, e;
    int          f0, r0, per, lw;
    lw = lanes;
    // 64-byte aligned start: no beat carries past the bits that reach the flash
    a = {lfsr[31:6], 6'h00};
    e = wide ? a : {8'h00, a[23:0]};
    f0 = frames;
    r0 = rises;
    for (int k = 0; k < n; k++) exp.push_back(~(e + 32'(4 * k)));
    stall = hold;
    @(negedge ref_clk);
    {req_valid, req} = {1'b1, a, 4'(n - 1)};
    @(negedge ref_clk);
    req_valid = 0;
    if (hold) begin
      // a full buffer must park the serial clock with select still low
      repeat (3000) @(negedge ref_clk);
      check(32'({pins.cs_n, pins.sck, req_ready, data_valid}), 32'h1);
      stall = 0;
    end
    for (int t = 0; t < 20000 && !(req_ready && got.size() == n); t++) @(negedge ref_clk);
    check(32'(req_ready), 32'h1);
    per = 8 + (wide ? 32 : 24) + DUMMY_CLKS_DEF + 32 / lw;
    check(32'(got.size()), 32'(n));
    while (got.size() > 0 && exp.size() > 0) check(got.pop_front(), exp.pop_front());
    exp.delete();
    check({24'h0, cmd}, {24'h0, READ_OPCODE});
    if (sp) begin
      check(32'(frames - f0), 32'(n));
      check(32'(rises - r0), 32'(n * per));
    end else begin
      check(32'(frames - f0), 32'h1);
      check(32'(rises - r0), 32'(per + (n - 1) * 32 / lw));
    end
  endtask : burst

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    final_report();
  end

  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 0;
    @(negedge ref_clk);
    check(32'({pins.cs_n, pins.sck, pins.oe, req_ready, data_valid}), 32'h80);
    rd(MODE_CTRL_ADDR, MODE_CTRL_RESET);
    rd(32'h0c000008, 32'h0);
    wr(MODE_CTRL_ADDR, 32'hffffffff);
    rd(MODE_CTRL_ADDR, MODE_CTRL_WMASK);
    check(32'(req_ready), 32'h1);
    strobe(BUS_CMD_ADDR, 32'h8, 1'b1);
    for (int p = 0; p < 8; p++) begin
      wr(MODE_CTRL_ADDR, 32'(p) << 9);
      rd(MODE_CTRL_ADDR, 32'(p) << 9);
    end
    check(32'(req_ready), 32'h0);
    strobe(BUS_CMD_ADDR, 32'h8, 1'b0);
    strobe(BUS_CMD_ADDR, 32'h0, 1'b0);
    strobe(BUS_CMD_ADDR, 32'h10, 1'b1);
    strobe(32'h0c000008, 32'h8, 1'b1);
    rd(BUS_CMD_ADDR, 32'h0);
    // every lane width meets rising, falling, pipe delay 0 and pipe delay 1 sampling, both address sizes, split and whole
    for (int k = 0; k < 12; k++) begin
      lanes = 3'(1 << (k % 3));
      wide = ((k / 3) % 2) == 1;
      wr(MODE_CTRL_ADDR, 32'h0);
      wr(BUS_CMD_ADDR, 32'(lanes));
      wr(MODE_CTRL_ADDR, 32'h1 | 32'(wide) << 13 | 32'(k >= 6) << 12 | cfg[k % 4]);
      burst(int'(lfsr[3:2]) + 1, k >= 6, 1'b0);
    end
    lanes = 3'h1;
    wide = 0;
    wr(MODE_CTRL_ADDR, 32'h0);
    wr(BUS_CMD_ADDR, 32'h1);
    wr(MODE_CTRL_ADDR, 32'h1);
    burst(8, 1'b0, 1'b1);
    final_report();
  end

endmodule : testbench

`default_nettype wire
